/* File: hw/gms_pkg.sv */
// Constants and types for the genset mains synchronisation supervisor.
// Assumes one 10 MHz clock and a one-second tick derived inside the supervisor.
// How it works
// R01 - Request plus preconditions starts synchronisation, reported outward
// R02 - Group sync output follows group synchronisation
// R03 - Mains sync output follows mains synchronisation
// R04 - In-progress output follows either synchronisation
// R05 - Synchronised output needs running sync and match
// R06 - Synchronised output drops once breaker closes
// R07 - Three status flags exposed to logic
// R08 - Auto sync in auto, test, remote, manual-if-set
// R09 - Ten seconds matched unclosed forces frequency slip
// R10 - Per-breaker nonzero timeout, automatic modes only
// R11 - Mains failure anomaly is always warning
// R12 - Group failure alarm if directly managed
// R13 - Manual mode still checks synchronised state
// R14 - Offsets 0-100 percent, 50 is nominal
// R15 - Analogue offset input overrides stored setting
// R16 - Manual: close command after synchronised closes breaker
// R17 - Policy 0: keep loads, retry after acknowledge
// R18 - Policy 1: open group, close mains unsynchronised
// R19 - Intervention inhibit overrides all, stops generators
// R20 - Intervention inhibit only in automatic mode
// R21 - Intervention inhibit raises no anomaly
// R22 - Any inhibit lights display lock indicator
// R23 - Sync ends on close, request loss, timeout
package gms_pkg;
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned TICK_CYCLES   = CLK_HZ;      // One second
  localparam int unsigned SLIP_HOLD_S   = 10;          // Matched hold before slip
  localparam int unsigned SLIP_TIME_S   = 2;           // Forced slip duration
  localparam int unsigned TIME_W        = 16;
  localparam logic [6:0]  OFFSET_NOMINAL = 7'h32;      // 50 percent
  localparam logic [6:0]  OFFSET_MAX     = 7'h64;      // 100 percent

  typedef enum logic [2:0] {
    GMS_MODE_OFF    = 3'h0,
    GMS_MODE_MAN    = 3'h1,
    GMS_MODE_AUTO   = 3'h2,
    GMS_MODE_TEST   = 3'h3,
    GMS_MODE_REMOTE = 3'h4
  } gms_mode_type;

  typedef enum logic [2:0] {
    GMS_ST_IDLE   = 3'h0,
    GMS_ST_SYNC   = 3'h1,
    GMS_ST_SLIP   = 3'h2,
    GMS_ST_FAILED = 3'h3,
    GMS_ST_BLACK  = 3'h4
  } gms_state_type;
endpackage : gms_pkg

/* File: hw/gms_sync_if.sv */
// Bundle between the supervisor and its per-breaker timeout channel.
// Assumes the supervisor drives the control side and reads the expiry.
`timescale 1ns/100ps
interface gms_sync_if #(parameter int unsigned TW = 16);
  logic          run;
  logic          tick;
  logic [TW-1:0] limit_s;
  logic          expired;
  modport ctrl (output run, output tick, output limit_s, input expired);
  modport chan (input run, input tick, input limit_s, output expired);
endinterface : gms_sync_if

/* File: hw/gms_timeout.sv */
// Per-breaker synchronisation duration supervisor, counts seconds ticks.
// Assumes tick is a one-cycle pulse once a second from the supervisor.
`timescale 1ns/100ps
module gms_timeout #(
  parameter int unsigned TW = 16
) (
  input  wire logic clock,
  input  wire logic srst,
  gms_sync_if.chan  bus
);
  logic [TW-1:0] secs_ff;
  logic [TW-1:0] nxt_secs;
  logic          exp_ff;
  logic          nxt_exp;

  // A zero limit disables supervision entirely
  always_comb begin
    nxt_secs = secs_ff;
    nxt_exp  = 1'b0;
    if (!bus.run) begin
      nxt_secs = '0;
    end else if (bus.limit_s != '0) begin // R10
      if (bus.tick && secs_ff != bus.limit_s)
        nxt_secs = secs_ff + 1'b1;
      nxt_exp = (secs_ff == bus.limit_s); // R10
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      secs_ff <= '0;
      exp_ff  <= 1'b0;
    end else begin
      secs_ff <= nxt_secs;
      exp_ff  <= nxt_exp;
    end
  end

  assign bus.expired = exp_ff;

  a_expiry_needs_run: assert property (@(posedge clock) disable iff (srst)
    bus.expired |-> $past(bus.run) && bus.limit_s != '0) // R10
    else $error("timeout expired without a running supervised sync");
endmodule : gms_timeout

/* File: hw/gms_supervisor.sv */
// Top of the genset mains synchronisation supervisor.
// Assumes all inputs are synchronous to clock; settings are static levels.
`timescale 1ns/100ps
module gms_supervisor #(
  parameter int unsigned TICK_CYC = gms_pkg::TICK_CYCLES
) (
  input  wire logic         clock,
  input  wire logic         srst,
  input  wire logic [2:0]   op_mode,
  input  wire logic         auto_sync_in_man,
  input  wire logic         use_external_sync,
  input  wire logic         group_brk_managed,
  input  wire logic         fail_policy,
  input  wire logic         mains_brk_sync_request_in,
  input  wire logic         group_brk_sync_request_in,
  input  wire logic         sync_preconditions_ok,
  input  wire logic         phase_matched,
  input  wire logic         mains_breaker_closed,
  input  wire logic         group_breaker_closed,
  input  wire logic         manual_close_cmd,
  input  wire logic         anomaly_ack,
  input  wire logic         gens_required,
  input  wire logic         auto_intervention_inhibit,
  input  wire logic         other_inhibit_active,
  input  wire logic [15:0]  mains_brk_max_sync_s,
  input  wire logic [15:0]  group_brk_max_sync_s,
  input  wire logic [6:0]   voltage_offset_set,
  input  wire logic [6:0]   speed_offset_set,
  input  wire logic         analog_voltage_offset_fn,
  input  wire logic [6:0]   analog_voltage_offset,
  input  wire logic         analog_speed_offset_fn,
  input  wire logic [6:0]   analog_speed_offset,
  output logic              group_brk_sync_out,
  output logic              mains_brk_sync_out,
  output logic              sync_in_progress_out,
  output logic              synchronised_out,
  output logic              flag_sync_mains_brk,
  output logic              flag_sync_group_brk,
  output logic              flag_synchronised,
  output logic              freq_slip_cmd,
  output logic              close_mains_brk_cmd,
  output logic              close_group_brk_cmd,
  output logic              force_open_group_brk,
  output logic              gens_shutdown,
  output logic              mains_brk_sync_fail_warning,
  output logic              group_brk_sync_fail_anomaly,
  output logic              group_fail_is_alarm,
  output logic              inhibit_lock_indicator,
  output logic [6:0]        voltage_offset_eff,
  output logic [6:0]        speed_offset_eff
);
  // The seconds divider is a 24-bit counter, so the period must fit in it
  if (TICK_CYC < 2 || TICK_CYC > 32'h01000000) begin : g_bad_tick
    $error("TICK_CYC must lie between 2 and 16777216");
  end

  localparam int unsigned SLIP_W = 4;

  gms_pkg::gms_state_type state_ff, nxt_state;
  logic        tgt_mains_ff, nxt_tgt_mains;
  logic [23:0] tick_cnt_ff, nxt_tick_cnt;
  logic        tick;
  logic [SLIP_W-1:0] hold_ff, nxt_hold;
  logic        warn_ff, nxt_warn;
  logic        anom_ff, nxt_anom;
  logic        sync_ff, nxt_sync_q;
  logic        match_ff, nxt_match;
  logic [6:0]  voff_ff, nxt_voff, soff_ff, nxt_soff;

  logic        is_auto_mode, mode_auto_sync, inhibit_act, mains_req, group_req;
  logic        brk_closed, sync_run, expired_m, expired_g;

  gms_sync_if #(.TW(gms_pkg::TIME_W)) tm_m ();
  gms_sync_if #(.TW(gms_pkg::TIME_W)) tm_g ();

  gms_timeout #(.TW(gms_pkg::TIME_W)) u_tmo_mains (.clock(clock), .srst(srst), .bus(tm_m));
  gms_timeout #(.TW(gms_pkg::TIME_W)) u_tmo_group (.clock(clock), .srst(srst), .bus(tm_g));

  // Seconds timebase
  always_comb begin
    tick         = (tick_cnt_ff == 24'(TICK_CYC - 1));
    nxt_tick_cnt = tick ? 24'h000000 : tick_cnt_ff + 24'h000001;
  end

  always_comb begin
    is_auto_mode   = (op_mode == gms_pkg::GMS_MODE_AUTO) ||
                     (op_mode == gms_pkg::GMS_MODE_TEST) ||
                     (op_mode == gms_pkg::GMS_MODE_REMOTE);
    mode_auto_sync = is_auto_mode ||
                     (op_mode == gms_pkg::GMS_MODE_MAN && auto_sync_in_man); // R08
    inhibit_act    = auto_intervention_inhibit &&
                     (op_mode == gms_pkg::GMS_MODE_AUTO); // R20
    mains_req      = mains_brk_sync_request_in && sync_preconditions_ok;
    group_req      = group_brk_sync_request_in && sync_preconditions_ok;
    brk_closed     = tgt_mains_ff ? mains_breaker_closed : group_breaker_closed;
    sync_run       = (state_ff == gms_pkg::GMS_ST_SYNC) ||
                     (state_ff == gms_pkg::GMS_ST_SLIP);
    expired_m      = tm_m.expired;
    expired_g      = tm_g.expired;
  end

  // Timeouts run only in the automatic modes, never in manual
  assign tm_m.run     = sync_run && tgt_mains_ff && is_auto_mode; // R10
  assign tm_g.run     = sync_run && !tgt_mains_ff && is_auto_mode; // R10
  assign tm_m.tick    = tick;
  assign tm_g.tick    = tick;
  assign tm_m.limit_s = mains_brk_max_sync_s;
  assign tm_g.limit_s = group_brk_max_sync_s;

  // Sequencer
  always_comb begin
    nxt_state     = state_ff;
    nxt_tgt_mains = tgt_mains_ff;
    nxt_hold      = hold_ff;
    nxt_warn      = warn_ff;
    nxt_anom      = anom_ff;
    if (anomaly_ack) begin
      nxt_warn = 1'b0;
      nxt_anom = 1'b0;
    end
    case (state_ff)
      gms_pkg::GMS_ST_IDLE: begin
        nxt_hold = '0;
        if (!inhibit_act && !warn_ff) begin // R19
          if (mains_req && !mains_breaker_closed) begin // R01
            nxt_state     = gms_pkg::GMS_ST_SYNC;
            nxt_tgt_mains = 1'b1;
          end else if (group_req && !group_breaker_closed) begin // R01
            nxt_state     = gms_pkg::GMS_ST_SYNC;
            nxt_tgt_mains = 1'b0;
          end
        end
      end
      gms_pkg::GMS_ST_SYNC, gms_pkg::GMS_ST_SLIP: begin
        if (tick && state_ff == gms_pkg::GMS_ST_SLIP) begin
          nxt_hold = hold_ff + 1'b1;
          if (hold_ff == SLIP_W'(gms_pkg::SLIP_TIME_S - 1)) begin // R09
            nxt_state = gms_pkg::GMS_ST_SYNC;
            nxt_hold  = '0;
          end
        end else if (state_ff == gms_pkg::GMS_ST_SYNC) begin
          if (!match_ff)
            nxt_hold = '0;
          else if (tick && mode_auto_sync && !use_external_sync) begin // R09
            nxt_hold = hold_ff + 1'b1;
            if (hold_ff == SLIP_W'(gms_pkg::SLIP_HOLD_S - 1)) begin
              nxt_state = gms_pkg::GMS_ST_SLIP;
              nxt_hold  = '0;
            end
          end
        end
        if (inhibit_act || brk_closed ||
            !(tgt_mains_ff ? mains_req : group_req)) begin // R23
          nxt_state = gms_pkg::GMS_ST_IDLE;
        end else if (expired_m) begin // R10
          nxt_warn  = 1'b1; // R11
          nxt_state = fail_policy ? gms_pkg::GMS_ST_BLACK : gms_pkg::GMS_ST_FAILED;
        end else if (expired_g) begin
          nxt_anom  = 1'b1;
          nxt_state = gms_pkg::GMS_ST_IDLE; // R23
        end
      end
      gms_pkg::GMS_ST_FAILED: begin
        if (anomaly_ack || !warn_ff) // R17
          nxt_state = gms_pkg::GMS_ST_IDLE;
      end
      gms_pkg::GMS_ST_BLACK: begin
        if (mains_breaker_closed || inhibit_act) begin // R18
          nxt_state = gms_pkg::GMS_ST_IDLE;
          nxt_warn  = 1'b0;
        end
      end
      default: nxt_state = gms_pkg::GMS_ST_IDLE;
    endcase
    // Expiry is a set event, it wins over a same-cycle acknowledge
    if (expired_m && sync_run && !inhibit_act) nxt_warn = 1'b1;
  end

  // Registered outputs
  always_comb begin
    nxt_sync_q = (nxt_state == gms_pkg::GMS_ST_SYNC) || (nxt_state == gms_pkg::GMS_ST_SLIP);
    nxt_match  = phase_matched && nxt_sync_q && (state_ff == gms_pkg::GMS_ST_SYNC)
                 && !brk_closed; // R05 R06 R13
    nxt_voff   = analog_voltage_offset_fn ? analog_voltage_offset : voltage_offset_set; // R15
    nxt_soff   = analog_speed_offset_fn ? analog_speed_offset : speed_offset_set; // R15
    if (nxt_voff > gms_pkg::OFFSET_MAX) nxt_voff = gms_pkg::OFFSET_MAX; // R14
    if (nxt_soff > gms_pkg::OFFSET_MAX) nxt_soff = gms_pkg::OFFSET_MAX; // R14
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state_ff     <= gms_pkg::GMS_ST_IDLE;
      tgt_mains_ff <= 1'b0;
      tick_cnt_ff  <= '0;
      hold_ff      <= '0;
      warn_ff      <= 1'b0;
      anom_ff      <= 1'b0;
      sync_ff      <= 1'b0;
      match_ff     <= 1'b0;
      voff_ff      <= gms_pkg::OFFSET_NOMINAL;
      soff_ff      <= gms_pkg::OFFSET_NOMINAL;
    end else begin
      state_ff     <= nxt_state;
      tgt_mains_ff <= nxt_tgt_mains;
      tick_cnt_ff  <= nxt_tick_cnt;
      hold_ff      <= nxt_hold;
      warn_ff      <= nxt_warn;
      anom_ff      <= nxt_anom;
      sync_ff      <= nxt_sync_q;
      match_ff     <= nxt_match;
      voff_ff      <= nxt_voff;
      soff_ff      <= nxt_soff;
    end
  end

  always_comb begin
    flag_sync_mains_brk  = sync_ff && tgt_mains_ff; // R07
    flag_sync_group_brk  = sync_ff && !tgt_mains_ff; // R07
    flag_synchronised    = match_ff; // R07
    mains_brk_sync_out   = flag_sync_mains_brk && use_external_sync; // R03
    group_brk_sync_out   = flag_sync_group_brk && use_external_sync; // R02
    sync_in_progress_out = sync_ff && use_external_sync; // R04
    synchronised_out     = match_ff; // R05
    freq_slip_cmd        = (state_ff == gms_pkg::GMS_ST_SLIP); // R09
    // Manual close only honoured while matched; auto close on match, group breaker only while gens_required
    close_mains_brk_cmd  = match_ff && tgt_mains_ff &&
                           (mode_auto_sync ? 1'b1 : manual_close_cmd) ||
                           (state_ff == gms_pkg::GMS_ST_BLACK && !group_breaker_closed); // R16 R18
    close_group_brk_cmd  = match_ff && !tgt_mains_ff &&
                           (mode_auto_sync ? gens_required : manual_close_cmd); // R16 R18
    force_open_group_brk = (state_ff == gms_pkg::GMS_ST_BLACK); // R18
    gens_shutdown        = inhibit_act; // R19 R21
    mains_brk_sync_fail_warning = warn_ff; // R11 R17
    group_brk_sync_fail_anomaly = anom_ff;
    group_fail_is_alarm  = anom_ff && group_brk_managed; // R12
    inhibit_lock_indicator = inhibit_act || other_inhibit_active; // R22
    voltage_offset_eff   = voff_ff;
    speed_offset_eff     = soff_ff;
  end

  a_sync_outs_flags: assert property (@(posedge clock) disable iff (srst)
    sync_in_progress_out |-> (flag_sync_mains_brk ^ flag_sync_group_brk)) // R04
    else $error("in-progress without exactly one breaker flag");
  a_synced_in_sync: assert property (@(posedge clock) disable iff (srst)
    synchronised_out |-> sync_ff && $past(phase_matched)) // R05
    else $error("synchronised while not syncing or unmatched");
  a_drop_on_close: assert property (@(posedge clock) disable iff (srst)
    sync_run && brk_closed |=> !synchronised_out && !sync_ff) // R06
    else $error("synchronised held after breaker closed");
  a_inhibit_stops: assert property (@(posedge clock) disable iff (srst)
    inhibit_act |=> !sync_ff) // R19
    else $error("sync kept running under intervention inhibit");
  a_inhibit_auto_only: assert property (@(posedge clock) disable iff (srst)
    gens_shutdown |-> op_mode == gms_pkg::GMS_MODE_AUTO) // R20
    else $error("intervention inhibit acted outside auto mode");
  a_start_on_request: assert property (@(posedge clock) disable iff (srst)
    state_ff == gms_pkg::GMS_ST_IDLE && !inhibit_act && !warn_ff && mains_req
    && !mains_breaker_closed |=> flag_sync_mains_brk) // R01
    else $error("mains request did not start synchronisation");
  a_mains_warn_set: assert property (@(posedge clock) disable iff (srst)
    sync_run && expired_m && !inhibit_act |=> mains_brk_sync_fail_warning) // R11
    else $error("mains timeout did not raise warning");
  a_offset_select: assert property (@(posedge clock) disable iff (srst)
    analog_voltage_offset_fn && analog_voltage_offset <= gms_pkg::OFFSET_MAX
    |=> voltage_offset_eff == $past(analog_voltage_offset)) // R15
    else $error("analogue voltage offset not taken");
  a_alarm_sev: assert property (@(posedge clock) disable iff (srst)
    group_fail_is_alarm |-> group_brk_managed && group_brk_sync_fail_anomaly) // R12
    else $error("group alarm without direct management");
  a_lock_ind: assert property (@(posedge clock) disable iff (srst)
    other_inhibit_active |-> inhibit_lock_indicator) // R22
    else $error("lock indicator missing under inhibit");

  c_mains_sync: cover property (@(posedge clock) disable iff (srst)
    flag_sync_mains_brk ##1 synchronised_out);
  c_slip: cover property (@(posedge clock) disable iff (srst) freq_slip_cmd);
  c_blackout: cover property (@(posedge clock) disable iff (srst)
    force_open_group_brk ##1 close_mains_brk_cmd);
  c_group_fail: cover property (@(posedge clock) disable iff (srst)
    group_brk_sync_fail_anomaly);
endmodule : gms_supervisor

/* File: testbench/gms_far_model.sv */
// Far-side model: synchro-check partner and the breaker closing logic.
// Assumes supervisor outputs are levels sampled on the rising clock edge.
`timescale 1ns/100ps
module gms_far_model (
  input  wire logic clock,
  input  wire logic srst,
  input  wire logic match_en,
  input  wire logic close_on_sync,
  input  wire logic target_mains,
  input  wire logic open_all,
  input  wire logic close_en,
  input  wire logic freq_slip_cmd,
  input  wire logic synchronised_out,
  input  wire logic close_mains_brk_cmd,
  input  wire logic close_group_brk_cmd,
  input  wire logic force_open_group_brk,
  output logic      phase_matched,
  output logic      mains_breaker_closed,
  output logic      group_breaker_closed
);
  // A forced slip really breaks the match, as the generators drift away
  assign phase_matched = match_en & ~freq_slip_cmd;
  always_ff @(posedge clock) begin
    if (srst | open_all) begin
      mains_breaker_closed <= 1'b0;
      group_breaker_closed <= 1'b0;
    end else begin
      // A disabled closer models a breaker that will not close on command
      if ((close_en & close_mains_brk_cmd) |
          (close_on_sync & synchronised_out & target_mains)) begin
        mains_breaker_closed <= 1'b1;
      end
      if (force_open_group_brk) begin
        group_breaker_closed <= 1'b0;
      end else if ((close_en & close_group_brk_cmd) |
                   (close_on_sync & synchronised_out & ~target_mains)) begin
        group_breaker_closed <= 1'b1;
      end
    end
  end
endmodule : gms_far_model

/* File: testbench/tb_top.sv */
// Self-checking bench for the synchronisation supervisor.
// Assumes a one-second tick of 10 clock cycles; inputs change on the falling edge.
`timescale 1ns/100ps
module tb_top;
  logic clock = 1'b0, srst = 1'b1, asm = 1'b0, ext = 1'b1, mgd = 1'b0, pol = 1'b0;
  logic mreq = 1'b0, greq = 1'b0, pre = 1'b1, mcmd = 1'b0, ack = 1'b0, need = 1'b1;
  logic inh = 1'b0, oinh = 1'b0, vfn = 1'b0, sfn = 1'b0, men = 1'b0, cos = 1'b0;
  logic tgt = 1'b1, opn = 1'b0, cen = 1'b0, pm, mc, gc;
  logic [2:0]  mode = gms_pkg::GMS_MODE_AUTO;
  logic [15:0] mmax = 16'h0, gmax = 16'h0;
  logic [6:0]  vset = 7'h32, sset = 7'h32, aval = 7'h50, veff, seff;
  logic gso, mso, sip, syn, fm, fg, fs, slip, cm, cg, fog, shut, wrn, gan, alm, lck;
  int   n_mismatch = 0;
  int   check_count = 0;
  logic [2:0] md [5] = '{3'h1, 3'h1, 3'h2, 3'h3, 3'h4};
  logic [6:0] vs [3] = '{7'h14, 7'h70, 7'h14};
  logic [6:0] ve [3] = '{7'h14, 7'h64, 7'h50};

  gms_supervisor #(.TICK_CYC(10)) dut (.clock(clock), .srst(srst), .op_mode(mode),
    .auto_sync_in_man(asm), .use_external_sync(ext), .group_brk_managed(mgd),
    .fail_policy(pol), .mains_brk_sync_request_in(mreq), .group_brk_sync_request_in(greq),
    .sync_preconditions_ok(pre), .phase_matched(pm), .mains_breaker_closed(mc),
    .group_breaker_closed(gc), .manual_close_cmd(mcmd), .anomaly_ack(ack),
    .gens_required(need), .auto_intervention_inhibit(inh), .other_inhibit_active(oinh),
    .mains_brk_max_sync_s(mmax), .group_brk_max_sync_s(gmax), .voltage_offset_set(vset),
    .speed_offset_set(sset), .analog_voltage_offset_fn(vfn), .analog_voltage_offset(aval),
    .analog_speed_offset_fn(sfn), .analog_speed_offset(aval), .group_brk_sync_out(gso),
    .mains_brk_sync_out(mso), .sync_in_progress_out(sip), .synchronised_out(syn),
    .flag_sync_mains_brk(fm), .flag_sync_group_brk(fg), .flag_synchronised(fs),
    .freq_slip_cmd(slip), .close_mains_brk_cmd(cm), .close_group_brk_cmd(cg),
    .force_open_group_brk(fog), .gens_shutdown(shut), .mains_brk_sync_fail_warning(wrn),
    .group_brk_sync_fail_anomaly(gan), .group_fail_is_alarm(alm),
    .inhibit_lock_indicator(lck), .voltage_offset_eff(veff), .speed_offset_eff(seff));

  gms_far_model far (.clock(clock), .srst(srst), .match_en(men), .close_on_sync(cos),
    .target_mains(tgt), .open_all(opn), .close_en(cen), .freq_slip_cmd(slip),
    .synchronised_out(syn),
    .close_mains_brk_cmd(cm), .close_group_brk_cmd(cg), .force_open_group_brk(fog),
    .phase_matched(pm), .mains_breaker_closed(mc), .group_breaker_closed(gc));

  initial begin
    forever #50 clock = ~clock;
  end

  task report_and_stop;
    $display("Comparisons %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop

  task chk(input logic [6:0] seen, input logic [6:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task step(input int n);
    repeat (n) @(negedge clock);
  endtask : step

  function automatic logic sig(input int s);
    case (s)
      0: return fm;
      3: return slip;
      4: return wrn;
      5: return gan;
      6: return cm;
      default: return mc;
    endcase
  endfunction : sig

  // Bounded wait; a missing expected event also ends the run
  task wait_hi(input int s, input int lim, input logic exp);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < lim && !hit; i++) begin
      step(1);
      hit = sig(s);
    end
    chk(7'(hit), 7'(exp));
    if (!hit && exp) report_and_stop();
  endtask : wait_hi

  task clean;
    mreq = 1'b0; greq = 1'b0; men = 1'b0; cos = 1'b0; mcmd = 1'b0; cen = 1'b0;
    step(3);
    ack = 1'b1; opn = 1'b1;
    step(1);
    ack = 1'b0; opn = 1'b0;
    step(3);
  endtask : clean

  initial begin
    step(8);
    srst = 1'b0;
    step(1);
    chk(veff, 7'h32);
    chk(7'(fm | fg | fs | syn | wrn | gan), 7'h0);
    mreq = 1'b1;
    step(3);
    chk({4'h0, mso, sip, gso}, 7'h06);
    chk({4'h0, fm, fg, syn}, 7'h04);
    men = 1'b1;
    step(3);
    chk({5'h0, syn, fs}, 7'h03);
    cos = 1'b1;
    wait_hi(7, 10, 1'b1);
    step(3);
    chk({4'h0, syn, mso, sip}, 7'h0);
    clean();
    greq = 1'b1; men = 1'b1;
    step(3);
    chk({4'h0, gso, fg, mso}, 7'h06);
    chk(7'(cg), 7'h1);
    greq = 1'b0;
    step(3);
    chk({5'h0, gso, sip}, 7'h0);
    ext = 1'b0;
    for (int i = 0; i < 5; i++) begin
      mode = md[i]; asm = (i == 1); men = 1'b1; mreq = 1'b1;
      step(4);
      chk(7'(syn), 7'h1);
      wait_hi(3, 150, i != 0);
      clean();
    end
    mode = gms_pkg::GMS_MODE_AUTO; ext = 1'b1; mmax = 16'h2;
    for (int p = 0; p < 2; p++) begin
      pol = p[0]; mreq = 1'b1;
      wait_hi(4, 60, 1'b1);
      chk(7'(gan), 7'h0);
      if (p == 0) begin
        step(20);
        chk(7'(fm), 7'h0);
        ack = 1'b1;
        step(1);
        ack = 1'b0;
        wait_hi(0, 10, 1'b1);
      end else begin
        chk(7'(fog), 7'h1);
        cen = 1'b1;
        wait_hi(6, 10, 1'b1);
        wait_hi(7, 10, 1'b1);
      end
      clean();
    end
    mode = gms_pkg::GMS_MODE_MAN; asm = 1'b1; mreq = 1'b1;
    wait_hi(4, 60, 1'b0);
    clean();
    mode = gms_pkg::GMS_MODE_AUTO; mmax = 16'h0; gmax = 16'h1;
    for (int m = 0; m < 2; m++) begin
      mgd = m[0]; greq = 1'b1;
      wait_hi(5, 40, 1'b1);
      chk(7'(alm), 7'(m[0]));
      clean();
    end
    inh = 1'b1; mreq = 1'b1; mmax = 16'h1;
    step(30);
    chk({4'h0, shut, fm, lck}, 7'h05);
    chk(7'(wrn | gan), 7'h0);
    mode = gms_pkg::GMS_MODE_TEST; mmax = 16'h0;
    step(4);
    chk({5'h0, shut, fm}, 7'h01);
    inh = 1'b0; oinh = 1'b1;
    step(1);
    chk(7'(lck), 7'h1);
    oinh = 1'b0;
    step(1);
    chk(7'(lck), 7'h0);
    clean();
    mode = gms_pkg::GMS_MODE_MAN; asm = 1'b0; ext = 1'b0; men = 1'b1; mreq = 1'b1;
    step(4);
    chk(7'(cm), 7'h0);
    mcmd = 1'b1;
    wait_hi(6, 5, 1'b1);
    clean();
    for (int k = 0; k < 3; k++) begin
      vset = vs[k]; sset = vs[k]; vfn = (k == 2); sfn = (k == 2);
      step(3);
      chk(veff, ve[k]);
      chk(seff, ve[k]);
    end
    report_and_stop();
  end

  initial begin
    repeat (100000) @(posedge clock);
    n_mismatch++;
    report_and_stop();
  end
endmodule : tb_top
